//--- sdba_pkg.sv
// Purpose: shared constants and types for the serial dma bus arbitration block
// Assumes: one clock, 32-byte system bus bursts
// Notes: requester 0 of the system arbiter is the engine
`default_nettype none
package sdba_pkg;
   localparam int SDBA_NREQ = 4;
   localparam int SDBA_LEN_W = 12;
   localparam logic [11:0] SDBA_BURST_BYTES = 12'h020;
   localparam logic [1:0] SDBA_PRIO_RST = 2'h0;
   localparam logic SDBA_LAST_RST = 1'h0;
   localparam logic [11:0] SDBA_LEN_RST = 12'h000;

   typedef enum logic [1:0] {
      SDBA_IDLE = 2'b00,
      SDBA_REQ = 2'b01,
      SDBA_XFER = 2'b10
   } sdba_state_t;

   // system bus transfer request from the engine core
   typedef struct packed {
      logic valid;
      logic [11:0] bytes;
   } sdba_xfer_t;

   // secondary bus request from the engine core
   typedef struct packed {
      logic valid;
      logic to_ddr;
   } sdba_sec_t;

   // grant pair at one secondary arbitration point
   typedef struct packed {
      logic eng;
      logic sysm;
   } sdba_pair_t;
endpackage
`default_nettype wire

//--- sdba_top.sv
// Purpose: bus access and arbitration for the serial dma engine
// Assumes: soft_reset_line_n_i is an asynchronous pin; all other inputs share mclk_i
// Notes: system and secondary channels are fully separate paths
//
// Summary of operation
// - recovery from a bus error needs the soft reset line, not a command.
// - during soft reset, flush all fifos and abandon outstanding transactions.
// - engine requests the system bus and waits for grant before transferring.
// - system arbiter resolves requests with four priority levels.
// - engine raises burst-continue hint when a transfer spans more than 32 bytes.
// - with hint present, arbiter keeps granting the same requester back to back.
// - secondary arbitration ignores all internal serial dma engine state.
// - secondary arbitration at local bus and ddr points, engine versus system master.
// - at the local bus point the system master always wins.
// - at the secondary ddr point arbitration uses rotating priority.
// - two physical channels: one system bus, one secondary bus.
// - secondary bus accesses never appear on the system bus.
`timescale 1ns/1ps
`default_nettype none
module sdba_top
   import sdba_pkg::*;
#(
   parameter int NREQ = sdba_pkg::SDBA_NREQ
)
(
   // clock and resets
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic soft_reset_line_n_i,
   // engine system channel
   input wire sdba_pkg::sdba_xfer_t eng_sys_req_i,
   input wire logic sys_beat_done_i,
   output logic eng_sys_busy_o,
   output logic eng_hint_o,
   output logic eng_sys_done_o,
   // system arbiter
   input wire logic [NREQ-1:1] oth_req_i,
   input wire logic [NREQ-1:1] oth_hint_i,
   input wire logic [2*NREQ-1:0] prio_i,
   output logic [NREQ-1:0] sys_gnt_o,
   // engine secondary channel
   input wire sdba_pkg::sdba_sec_t eng_sec_req_i,
   input wire logic sec_ack_i,
   // system masters at secondary points
   input wire logic sysm_lbc_req_i,
   input wire logic sysm_ddr_req_i,
   output sdba_pkg::sdba_pair_t lbc_gnt_o,
   output sdba_pkg::sdba_pair_t ddr_gnt_o,
   // fifo flush
   output logic fifo_flush_o
);
   import sdba_pkg::*;

   // highest level wins, ties go to the lowest index
   function automatic logic [NREQ-1:0] pick(input logic [NREQ-1:0] req,
                                            input logic [2*NREQ-1:0] pr);
      logic [NREQ-1:0] g;
      logic [1:0] best;
      g = '0;
      best = SDBA_PRIO_RST;
      for (int i = 0; i < NREQ; i++)
      begin
         if (req[i] && (g == '0 || pr[2*i +: 2] > best))
         begin
            g = '0;
            g[i] = 1'b1;
            best = pr[2*i +: 2];
         end
      end
      return g;
   endfunction

   logic srst_meta_r, srst_sync_r;
   wire logic clr;
   sdba_state_t state_r, state_nxt;
   logic [11:0] left_r, left_nxt;
   logic [NREQ-1:0] gnt_r, gnt_nxt;
   logic done_r, hint_r, busy_r, flush_r;
   logic sec_pend_r, sec_ddr_r, last_eng_r;
   sdba_pair_t lbc_r, ddr_r, lbc_nxt, ddr_nxt;

   // pin passes two flops before use
   always_ff @(posedge mclk_i)
   begin
      srst_meta_r <= ~soft_reset_line_n_i;
      srst_sync_r <= srst_meta_r;
   end

   // soft reset recovery: the synchronised line clears everything, no command path
   assign clr = ~rst_n_i | srst_sync_r;

   // system channel
   wire logic eng_req;
   wire logic [NREQ-1:0] all_req;
   wire logic [NREQ-1:0] all_hint;
   wire logic more;
   wire logic owner_keep;
   // hint: more than one burst still to move
   assign more = left_r > SDBA_BURST_BYTES;
   // request first: engine requests in REQ and XFER only
   assign eng_req = (state_r != SDBA_IDLE);
   assign all_req = {oth_req_i, eng_req};
   assign all_hint = {oth_hint_i, more & eng_req};
   // back to back: a hinting owner keeps the bus past a burst end
   assign owner_keep = |(gnt_r & all_req & (~{NREQ{sys_beat_done_i}} | all_hint));

   always_comb
   begin
      // four levels: arbitrate when the bus is free
      gnt_nxt = owner_keep ? gnt_r : pick(all_req, prio_i);
      state_nxt = state_r;
      left_nxt = left_r;
      unique case (state_r)
         SDBA_IDLE:
         begin
            if (eng_sys_req_i.valid)
            begin
               state_nxt = SDBA_REQ;
               left_nxt = eng_sys_req_i.bytes;
            end
         end
         SDBA_REQ:
         begin
            if (gnt_r[0])
               state_nxt = SDBA_XFER;
         end
         SDBA_XFER:
         begin
            if (sys_beat_done_i && gnt_r[0])
            begin
               left_nxt = more ? left_r - SDBA_BURST_BYTES : SDBA_LEN_RST;
               if (!more)
                  state_nxt = SDBA_IDLE;
            end
         end
         default:
            state_nxt = SDBA_IDLE;
      endcase
      if (state_nxt == SDBA_IDLE)
         gnt_nxt[0] = 1'b0;
   end

   // flush and abandon: all channel state cleared under soft reset
   always_ff @(posedge mclk_i)
   begin
      if (clr)
      begin
         state_r <= SDBA_IDLE;
         left_r <= SDBA_LEN_RST;
         gnt_r <= '0;
         done_r <= 1'b0;
         hint_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         left_r <= left_nxt;
         gnt_r <= gnt_nxt;
         done_r <= (state_r == SDBA_XFER) && (state_nxt == SDBA_IDLE);
         hint_r <= (state_nxt != SDBA_IDLE) && (left_nxt > SDBA_BURST_BYTES);
         busy_r <= (state_nxt != SDBA_IDLE);
      end
   end

   always_ff @(posedge mclk_i)
   begin
      flush_r <= clr;
   end

   // second channel: secondary requests use their own pending flop
   always_ff @(posedge mclk_i)
   begin
      if (clr)
      begin
         sec_pend_r <= 1'b0;
         sec_ddr_r <= 1'b0;
      end
      else if (!sec_pend_r && eng_sec_req_i.valid)
      begin
         sec_pend_r <= 1'b1;
         sec_ddr_r <= eng_sec_req_i.to_ddr;
      end
      else if (sec_ack_i)
         sec_pend_r <= 1'b0;
   end

   // engine state free: only request lines, sec_ack_i and the last ddr winner feed these decisions
   wire logic e_lbc;
   wire logic e_ddr;
   // kept off the system bus: no path into all_req
   // completing cycle drops out, so a finished access gets no stray grant
   assign e_lbc = sec_pend_r & ~sec_ack_i & ~sec_ddr_r;
   assign e_ddr = sec_pend_r & ~sec_ack_i & sec_ddr_r;
   // system master wins at local bus
   assign lbc_nxt.sysm = sysm_lbc_req_i;
   assign lbc_nxt.eng = e_lbc & ~sysm_lbc_req_i;
   // last winner yields on a tie
   assign ddr_nxt.eng = e_ddr & (~sysm_ddr_req_i | ~last_eng_r);
   assign ddr_nxt.sysm = sysm_ddr_req_i & (~e_ddr | last_eng_r);

   always_ff @(posedge mclk_i)
   begin
      if (clr)
      begin
         lbc_r <= '0;
         ddr_r <= '0;
         last_eng_r <= SDBA_LAST_RST;
      end
      else
      begin
         lbc_r <= lbc_nxt;
         ddr_r <= ddr_nxt;
         if (ddr_nxt.eng | ddr_nxt.sysm)
            last_eng_r <= ddr_nxt.eng;
      end
   end

   assign sys_gnt_o = gnt_r;
   assign eng_sys_busy_o = busy_r;
   assign eng_hint_o = hint_r;
   assign eng_sys_done_o = done_r;
   assign lbc_gnt_o = lbc_r;
   assign ddr_gnt_o = ddr_r;
   assign fifo_flush_o = flush_r;

   // checks
   sequence s_req_wait;
      (state_r == SDBA_REQ) && !gnt_r[0];
   endsequence
   sequence s_xfer;
      state_r == SDBA_XFER;
   endsequence

   flush_clears_a: assert property (
      @(posedge mclk_i) srst_sync_r |=>
         (state_r == SDBA_IDLE) && (gnt_r == '0) && !sec_pend_r && fifo_flush_o)
      else $error("soft reset left state");
   grant_before_xfer_a: assert property (
      @(posedge mclk_i) disable iff (clr) s_req_wait |=> (state_r != SDBA_XFER))
      else $error("transfer without grant");
   xfer_granted_a: assert property (
      @(posedge mclk_i) disable iff (clr) s_xfer |-> sys_gnt_o[0])
      else $error("transfer while not granted");
   hint_level_a: assert property (
      @(posedge mclk_i) disable iff (clr)
         eng_hint_o == (eng_sys_busy_o && (left_r > SDBA_BURST_BYTES)))
      else $error("hint mismatch");
   grant_onehot_a: assert property (
      @(posedge mclk_i) disable iff (clr) $onehot0(sys_gnt_o))
      else $error("two system grants");
   hint_holds_a: assert property (
      @(posedge mclk_i) disable iff (clr)
         (|(gnt_r & all_req & all_hint)) |=> $stable(gnt_r) || clr)
      else $error("hinting owner lost bus");
   lbc_sys_wins_a: assert property (
      @(posedge mclk_i) disable iff (clr)
         sysm_lbc_req_i |=> lbc_gnt_o.sysm && !lbc_gnt_o.eng)
      else $error("engine beat system master");
   ddr_rotate_a: assert property (
      @(posedge mclk_i) disable iff (clr)
         (ddr_gnt_o.eng && e_ddr && sysm_ddr_req_i) |=> ddr_gnt_o.sysm)
      else $error("ddr did not rotate");
   ddr_exclusive_a: assert property (
      @(posedge mclk_i) disable iff (clr) !(ddr_gnt_o.eng && ddr_gnt_o.sysm))
      else $error("ddr double grant");
   sec_off_sys_a: assert property (
      @(posedge mclk_i) disable iff (clr)
         (sec_pend_r && state_r == SDBA_IDLE) |=> !sys_gnt_o[0])
      else $error("secondary on system bus");
endmodule
`default_nettype wire

//--- sdba_far_model.sv
// Purpose: far side of the block: system bus beats and secondary acks
// Assumes: one beat every second granted cycle, ack one cycle after grant
// Notes: never answers without a grant, like the real memory side
`timescale 1ns/1ps
`default_nettype none
module sdba_far_model
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // grants from the block
   input wire logic eng_gnt_i,
   input wire logic sec_gnt_i,
   // completions
   output logic beat_done_o = 1'b0,
   output logic sec_ack_o = 1'b0
);
   logic half_r = 1'b0;
   always @(posedge mclk_i)
   begin
      half_r <= rst_n_i && eng_gnt_i && !half_r;
      beat_done_o <= rst_n_i && eng_gnt_i && half_r;
   end
   always @(posedge mclk_i)
   begin
      sec_ack_o <= rst_n_i && sec_gnt_i && !sec_ack_o;
   end
endmodule
`default_nettype wire

//--- sdba_top_test.sv
// Purpose: self-checking bench for the serial dma bus arbitration block
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: hints of other masters stay low, so only the engine hint is seen
`timescale 1ns/1ps
`default_nettype none
module sdba_top_test;
   import sdba_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic soft_reset_line_n_i = 1'b1;
   sdba_xfer_t eng_sys_req_i = '0;
   logic sys_beat_done_i, eng_sys_busy_o, eng_hint_o, eng_sys_done_o, sec_ack_i, fifo_flush_o;
   logic [3:1] oth_req_i = 3'h0;
   logic [7:0] prio_i = 8'h00;
   logic [3:0] sys_gnt_o;
   sdba_sec_t eng_sec_req_i = '0;
   logic sysm_lbc_req_i = 1'b0;
   logic sysm_ddr_req_i = 1'b0;
   sdba_pair_t lbc_gnt_o, ddr_gnt_o;
   int mismatches = 0;
   int comparisons = 0;
   int beats = 0;
   sdba_top sdba_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .soft_reset_line_n_i(soft_reset_line_n_i), .eng_sys_req_i(eng_sys_req_i),
      .sys_beat_done_i(sys_beat_done_i), .eng_sys_busy_o(eng_sys_busy_o),
      .eng_hint_o(eng_hint_o), .eng_sys_done_o(eng_sys_done_o), .oth_req_i(oth_req_i),
      .oth_hint_i(3'h0), .prio_i(prio_i), .sys_gnt_o(sys_gnt_o), .eng_sec_req_i(eng_sec_req_i),
      .sec_ack_i(sec_ack_i), .sysm_lbc_req_i(sysm_lbc_req_i), .sysm_ddr_req_i(sysm_ddr_req_i),
      .lbc_gnt_o(lbc_gnt_o), .ddr_gnt_o(ddr_gnt_o), .fifo_flush_o(fifo_flush_o));
   sdba_far_model sdba_far_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .eng_gnt_i(sys_gnt_o[0]), .sec_gnt_i(lbc_gnt_o.eng | ddr_gnt_o.eng),
      .beat_done_o(sys_beat_done_i), .sec_ack_o(sec_ack_i));
   initial
   begin
      forever #4 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      if (sys_beat_done_i === 1'b1)
         beats <= beats + 1;
   end
   task automatic tally_and_finish();
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic cond(input int sel);
      case (sel)
         0: return sys_gnt_o[0];
         1: return eng_sys_done_o;
         2: return lbc_gnt_o.eng;
         3: return ddr_gnt_o.eng;
         4: return ddr_gnt_o.sysm;
         5: return fifo_flush_o;
         6: return !fifo_flush_o;
         default: return !lbc_gnt_o.eng;
      endcase
   endfunction
   // bounded wait; running out ends the run
   task automatic wait_til(input int sel);
      int n;
      for (n = 0; n < 40 && cond(sel) !== 1'b1; n++)
         @(negedge mclk_i);
      chk(cond(sel), 1'b1);
      if (n == 40)
         tally_and_finish();
   endtask
   task automatic sys_walk();
      prio_i = 8'hC0;
      oth_req_i = 3'h4;
      @(negedge mclk_i);
      eng_sys_req_i = '{1'b1, 12'h040};
      @(negedge mclk_i);
      eng_sys_req_i = '0;
      repeat (3) @(negedge mclk_i);
      chk(sys_gnt_o, 4'h8);
      chk(eng_hint_o, 1'b1);
      oth_req_i = 3'h0;
      wait_til(0);
      beats = 0;
      oth_req_i = 3'h4;
      wait_til(1);
      chk(beats, 2);
      chk(eng_hint_o, 1'b0);
      @(negedge mclk_i);
      chk(sys_gnt_o, 4'h8);
      oth_req_i = 3'h0;
   endtask
   task automatic lbc_turn();
      sysm_lbc_req_i = 1'b1;
      eng_sec_req_i = '{1'b1, 1'b0};
      @(negedge mclk_i);
      eng_sec_req_i = '0;
      repeat (4) @(negedge mclk_i);
      chk(lbc_gnt_o, 2'h1);
      chk(sys_gnt_o, 4'h0);
      sysm_lbc_req_i = 1'b0;
      wait_til(2);
      // access must complete before the next secondary request is taken
      wait_til(7);
   endtask
   task automatic ddr_turn();
      sysm_ddr_req_i = 1'b1;
      wait_til(4);
      eng_sec_req_i = '{1'b1, 1'b1};
      @(negedge mclk_i);
      eng_sec_req_i = '0;
      wait_til(3);
      wait_til(4);
      sysm_ddr_req_i = 1'b0;
   endtask
   task automatic soft_flush();
      prio_i = 8'h03;
      eng_sys_req_i = '{1'b1, 12'h060};
      @(negedge mclk_i);
      eng_sys_req_i = '0;
      repeat (2) @(negedge mclk_i);
      chk(eng_sys_busy_o, 1'b1);
      soft_reset_line_n_i = 1'b0;
      wait_til(5);
      chk({eng_sys_busy_o, sys_gnt_o}, 5'h00);
      soft_reset_line_n_i = 1'b1;
      wait_til(6);
   endtask
   initial
   begin
      repeat (8) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      sys_walk();
      lbc_turn();
      ddr_turn();
      soft_flush();
      // recovery after the soft reset
      sys_walk();
      tally_and_finish();
   end
endmodule
`default_nettype wire
